// ==== design/option_byte_loader.v ====
// How it works
// - After reset the option area is locked; changes are refused until unlocked.
// - Unlock only through the option key register, never the flash key register.
// - No software lock; once unlocked it stays so until reset.
// - Programmed option values take effect only after the next reset reload.
// - Each reset reads all 16 option bytes into option and protect registers.
// - Eight configurable bytes at even addresses, complements at odd addresses.
// - Byte not matching its complement sets error flag and loads 0xFF.
// - Byte and complement both 0xFF skip the check, no error.
// - User byte: bit0 watchdog, bit1 stop reset, bit2 standby reset, bit4 boot.
// - User byte: bit5 analog monitor, bit6 RAM parity; bits 3, 7 reserved.
// - Write-protect bit 0 protects its page group, 1 leaves it open.
// - Each bit covers four pages; bytes 0..3 map pages 0-31 up to 96-127.
// - Read and write protection are independent; unprotecting erases nothing.
// - Read protect 0xAA is level 0, 0xCC level 2, others level 1.
// - Option erase or write completion sets the complete flag and interrupt.
`include "option_loader_regs.vh"
`default_nettype none

module option_byte_loader (
  input wire core_clk,
  input wire rst,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata,
  output wire irq,
  output reg [3:0] ib_addr,
  output reg ib_rd,
  input wire [7:0] ib_rdata,
  output reg ib_prog,
  output reg [2:0] ib_prog_index,
  output reg [7:0] ib_prog_data,
  output reg ib_erase,
  input wire ib_op_done,
  output reg options_valid,
  output reg [1:0] read_protect_level,
  output reg debug_disable,
  output reg watchdog_select,
  output reg no_reset_on_stop,
  output reg no_reset_on_standby,
  output reg boot_select_bit,
  output reg analog_supply_monitor_enable,
  output reg ram_parity_enable,
  output reg [31:0] page_group_protect
);

  localparam S_START = 2'd0;
  localparam S_READ = 2'd1;
  localparam S_CHECK = 2'd2;
  localparam S_DONE = 2'd3;

  function [1:0] level_of;
    input [7:0] code;
    begin
      if (code == `RDP_LEVEL0_CODE) begin
        level_of = `LEVEL0;
      end else if (code == `RDP_LEVEL2_CODE) begin
        level_of = `LEVEL2;
      end else begin
        level_of = `LEVEL1;
      end
    end
  endfunction

  reg [1:0] state_reg;
  reg [4:0] rd_count_reg;
  reg rd_pending_reg;
  reg [3:0] rd_index_reg;
  reg [7:0] raw_reg [0:`OPT_BYTES-1];
  reg [31:0] obcs_reg;
  reg [31:0] wrtprot_reg;
  reg key_stage_reg;
  reg opt_unlocked_reg;
  reg busy_reg;
  reg op_complete_reg;
  reg complete_ie_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_mask_reg;
  reg [10:0] opt_data_reg;
  reg load_err_event;

  wire [7:0] pair_value [0:`OPT_PAIRS-1];
  wire [`OPT_PAIRS-1:0] pair_mismatch;
  wire [1:0] loaded_level;
  wire [7:0] user_opt;
  wire wr_opt_key;
  wire wr_ctrl2;
  wire level2_now;
  wire done_event;
  wire start_ok;

  genvar gi;
  generate
    for (gi = 0; gi < `OPT_PAIRS; gi = gi + 1) begin : g_pair
      option_pair_check u_check (
        .cfg_byte(raw_reg[2*gi]),
        .cmp_byte(raw_reg[2*gi+1]),
        .loaded_byte(pair_value[gi]),
        .mismatch(pair_mismatch[gi])
      );
    end
  endgenerate

  assign loaded_level = level_of(pair_value[0]);
  assign user_opt = pair_value[1];
  assign level2_now = (obcs_reg[`OBCS_LEVEL_LSB +: 2] == `LEVEL2);
  assign wr_opt_key = wr_en && (addr == `OPTION_KEY_OFS);
  assign wr_ctrl2 = wr_en && (addr == `CTRL2_OFS);
  assign done_event = busy_reg && ib_op_done;
  assign start_ok = opt_unlocked_reg && !busy_reg && options_valid && !level2_now;
  assign irq = |(irq_status_reg & irq_mask_reg);

  // Reload sequencer: reads run once after each reset
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= S_START;
      rd_count_reg <= 5'd0;
      rd_pending_reg <= 1'b0;
      rd_index_reg <= 4'd0;
      ib_addr <= 4'd0;
      ib_rd <= 1'b0;
      options_valid <= 1'b0;
      load_err_event <= 1'b0;
    end else begin
      ib_rd <= 1'b0;
      load_err_event <= 1'b0;
      rd_pending_reg <= ib_rd;
      rd_index_reg <= ib_addr;
      case (state_reg)
        S_START: begin
          rd_count_reg <= 5'd0;
          state_reg <= S_READ;
        end
        S_READ: begin
          if (rd_count_reg < `OPT_BYTES) begin
            ib_rd <= 1'b1;
            ib_addr <= rd_count_reg[3:0];
            rd_count_reg <= rd_count_reg + 5'd1;
          end else if (!rd_pending_reg && !ib_rd) begin
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          load_err_event <= |pair_mismatch;
          options_valid <= 1'b1;
          state_reg <= S_DONE;
        end
        S_DONE: begin
          state_reg <= S_DONE;
        end
        default: begin
          state_reg <= S_START;
        end
      endcase
    end
  end

  integer bi;
  always @(posedge core_clk) begin
    if (rst) begin
      for (bi = 0; bi < `OPT_BYTES; bi = bi + 1) begin
        raw_reg[bi] <= `ERASED_BYTE;
      end
    end else if (rd_pending_reg) begin
      raw_reg[rd_index_reg] <= ib_rdata;
    end
  end

  // Loaded registers change only at the end of a reload
  always @(posedge core_clk) begin
    if (rst) begin
      obcs_reg <= `RESET_OBCS;
      wrtprot_reg <= `RESET_WRTPROT;
      read_protect_level <= `LEVEL1;
      debug_disable <= 1'b0;
      watchdog_select <= 1'b1;
      no_reset_on_stop <= 1'b1;
      no_reset_on_standby <= 1'b1;
      boot_select_bit <= 1'b1;
      analog_supply_monitor_enable <= 1'b0;
      ram_parity_enable <= 1'b0;
      page_group_protect <= 32'h0000_0000;
    end else if (state_reg == S_CHECK) begin
      obcs_reg <= {pair_value[3], pair_value[2], user_opt, 5'd0, loaded_level, |pair_mismatch};
      wrtprot_reg <= {pair_value[7], pair_value[6], pair_value[5], pair_value[4]};
      read_protect_level <= loaded_level;
      debug_disable <= (loaded_level == `LEVEL2);
      watchdog_select <= user_opt[`USER_WDT_BIT];
      no_reset_on_stop <= user_opt[`USER_STOP_BIT];
      no_reset_on_standby <= user_opt[`USER_STANDBY_BIT];
      boot_select_bit <= user_opt[`USER_BOOT_BIT];
      analog_supply_monitor_enable <= user_opt[`USER_ANALOG_BIT];
      ram_parity_enable <= user_opt[`USER_PARITY_BIT];
      // Bit n of the word guards pages 4n to 4n+3; 1 means protected
      page_group_protect <= ~{pair_value[7], pair_value[6], pair_value[5], pair_value[4]};
    end
  end

  // Option key sequence; a wrong word restarts it
  always @(posedge core_clk) begin
    if (rst) begin
      key_stage_reg <= 1'b0;
      opt_unlocked_reg <= 1'b0;
    end else if (wr_opt_key && !opt_unlocked_reg && !level2_now) begin
      if (!key_stage_reg && wdata == `KEY_FIRST) begin
        key_stage_reg <= 1'b1;
      end else if (key_stage_reg && wdata == `KEY_SECOND) begin
        opt_unlocked_reg <= 1'b1;
        key_stage_reg <= 1'b0;
      end else begin
        key_stage_reg <= 1'b0;
      end
    end
  end

  // Option program and erase commands
  always @(posedge core_clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
      complete_ie_reg <= 1'b0;
      opt_data_reg <= 11'd0;
      ib_prog <= 1'b0;
      ib_erase <= 1'b0;
      ib_prog_index <= 3'd0;
      ib_prog_data <= 8'h00;
    end else begin
      ib_prog <= 1'b0;
      ib_erase <= 1'b0;
      if (wr_en && addr == `OPT_DATA_OFS) begin
        opt_data_reg <= wdata[10:0];
      end
      if (done_event) begin
        busy_reg <= 1'b0;
      end
      if (wr_ctrl2) begin
        complete_ie_reg <= wdata[`C2_DONE_IE_BIT];
        if (start_ok && wdata[`C2_ERASE_BIT]) begin
          ib_erase <= 1'b1;
          busy_reg <= 1'b1;
        end else if (start_ok && wdata[`C2_PROG_BIT]) begin
          ib_prog <= 1'b1;
          ib_prog_index <= opt_data_reg[`OPT_ADDR_LSB +: 3];
          ib_prog_data <= opt_data_reg[7:0];
          busy_reg <= 1'b1;
        end
      end
    end
  end

  // Flags: a hardware set wins over a clear in the same cycle
  always @(posedge core_clk) begin
    if (rst) begin
      op_complete_reg <= 1'b0;
      irq_status_reg <= 2'b00;
      irq_mask_reg <= 2'b00;
    end else begin
      if (done_event) begin
        op_complete_reg <= 1'b1;
      end else if (wr_en && addr == `STATUS_OFS && wdata[`ST_DONE_BIT]) begin
        op_complete_reg <= 1'b0;
      end
      if (wr_en && addr == `IRQ_MASK_OFS) begin
        irq_mask_reg <= wdata[1:0];
      end
      irq_status_reg[`IRQ_DONE_BIT] <= (done_event && complete_ie_reg) ||
        (irq_status_reg[`IRQ_DONE_BIT] && !(rd_en && addr == `IRQ_STATUS_OFS));
      irq_status_reg[`IRQ_LOAD_ERR_BIT] <= load_err_event ||
        (irq_status_reg[`IRQ_LOAD_ERR_BIT] && !(rd_en && addr == `IRQ_STATUS_OFS));
    end
  end

  // Read data, one cycle after the strobe; key registers read zero
  always @(posedge core_clk) begin
    if (rst) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (addr)
        `STATUS_OFS: rdata <= {26'd0, op_complete_reg, 4'd0, busy_reg};
        `CTRL2_OFS: rdata <= {28'd0, opt_unlocked_reg, complete_ie_reg, 2'b00};
        `OBCS_OFS: rdata <= obcs_reg;
        `WRTPROT_OFS: rdata <= wrtprot_reg;
        `IRQ_STATUS_OFS: rdata <= {30'd0, irq_status_reg};
        `IRQ_MASK_OFS: rdata <= {30'd0, irq_mask_reg};
        `OPT_DATA_OFS: rdata <= {21'd0, opt_data_reg};
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule // option_byte_loader

`default_nettype wire

// ==== include/option_loader_regs.vh ====
`ifndef OPTION_LOADER_REGS_VH
`define OPTION_LOADER_REGS_VH

// Register offsets, byte addresses
`define FLASH_KEY_OFS 8'h04
`define OPTION_KEY_OFS 8'h08
`define STATUS_OFS 8'h0C
`define CTRL2_OFS 8'h10
`define OBCS_OFS 8'h1C
`define WRTPROT_OFS 8'h20
`define IRQ_STATUS_OFS 8'h24
`define IRQ_MASK_OFS 8'h28
`define OPT_DATA_OFS 8'h2C

// Unlock keys
`define KEY_FIRST 32'h4567_0123
`define KEY_SECOND 32'hCDEF_89AB

// Status register fields
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 5

// Control register 2 fields
`define C2_PROG_BIT 0
`define C2_ERASE_BIT 1
`define C2_DONE_IE_BIT 2
`define C2_OPT_WEN_BIT 3

// Option control/status register fields
`define OBCS_ERR_BIT 0
`define OBCS_LEVEL_LSB 1
`define OBCS_USER_LSB 8
`define OBCS_UDATA0_LSB 16
`define OBCS_UDATA1_LSB 24

// Interrupt status/mask fields
`define IRQ_DONE_BIT 0
`define IRQ_LOAD_ERR_BIT 1

// Option byte option data register fields
`define OPT_ADDR_LSB 8

// User option byte fields
`define USER_WDT_BIT 0
`define USER_STOP_BIT 1
`define USER_STANDBY_BIT 2
`define USER_BOOT_BIT 4
`define USER_ANALOG_BIT 5
`define USER_PARITY_BIT 6

// Read protection codes and levels
`define RDP_LEVEL0_CODE 8'hAA
`define RDP_LEVEL2_CODE 8'hCC
`define LEVEL0 2'h0
`define LEVEL1 2'h1
`define LEVEL2 2'h2

// Option area layout
`define OPT_BYTES 16
`define OPT_PAIRS 8
`define ERASED_BYTE 8'hFF
`define RESET_OBCS 32'h0000_0002
`define RESET_WRTPROT 32'hFFFF_FFFF

`endif

// ==== design/option_pair_check.v ====
`include "option_loader_regs.vh"
`default_nettype none

module option_pair_check (
  input wire [7:0] cfg_byte,
  input wire [7:0] cmp_byte,
  output wire [7:0] loaded_byte,
  output wire mismatch
);

  wire erased;

  assign erased = (cfg_byte == `ERASED_BYTE) && (cmp_byte == `ERASED_BYTE);
  assign mismatch = !erased && (cfg_byte != ~cmp_byte);
  assign loaded_byte = mismatch ? `ERASED_BYTE : cfg_byte;

endmodule // option_pair_check

`default_nettype wire

// ==== test/option_byte_loader_properties.sv ====
`default_nettype none
module option_byte_loader_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic [3:0] ib_addr,
  input wire logic ib_rd,
  input wire logic ib_prog,
  input wire logic ib_erase,
  input wire logic options_valid,
  input wire logic [1:0] read_protect_level,
  input wire logic debug_disable,
  input wire logic [31:0] page_group_protect
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_first_reads;
    ib_rd && ib_addr == 4'h0 ##1 ib_rd && ib_addr == 4'h1;
  endsequence
  sequence s_last_read;
    ib_rd && ib_addr == 4'hf;
  endsequence
  a_reload_start: assert property ($fell(rst) |-> ##[0:2] s_first_reads)
    else $error("reload did not start");
  a_valid_late: assert property (s_last_read |-> ##4 $rose(options_valid))
    else $error("options released at wrong time");
  a_valid_holds: assert property (options_valid |=> options_valid)
    else $error("options_valid dropped");
  a_no_reread: assert property (options_valid |-> !ib_rd)
    else $error("reload outside reset");
  a_outputs_frozen: assert property (options_valid && $past(options_valid) |->
    $stable(page_group_protect) && $stable(read_protect_level))
    else $error("loaded outputs changed");
  a_debug_level: assert property (options_valid |->
    debug_disable == (read_protect_level == 2'h2))
    else $error("debug disable wrong");
  a_cmd_gated: assert property (ib_prog || ib_erase |->
    options_valid && read_protect_level != 2'h2)
    else $error("command not allowed");
  a_key_reads_zero: assert property (rd_en && (addr == 8'h04 || addr == 8'h08) |=>
    rdata == 32'h0)
    else $error("key register read nonzero");
endmodule // option_byte_loader_chk
bind option_byte_loader option_byte_loader_chk u_chk (.core_clk, .rst, .addr, .rd_en,
  .rdata, .ib_addr, .ib_rd, .ib_prog, .ib_erase, .options_valid, .read_protect_level,
  .debug_disable, .page_group_protect);
`default_nettype wire

// ==== test/info_block_model.sv ====
`default_nettype none
module info_block_model (
  input wire logic core_clk,
  input wire logic [3:0] ib_addr,
  input wire logic ib_rd,
  output logic [7:0] ib_rdata,
  input wire logic ib_prog,
  input wire logic [2:0] ib_prog_index,
  input wire logic [7:0] ib_prog_data,
  input wire logic ib_erase,
  output logic ib_op_done,
  input wire logic [3:0] done_delay
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:15];
  int cnt = 0;
  initial ib_rdata = 8'h00;
  initial ib_op_done = 1'b0;
  always @(posedge core_clk) begin
    // Idle data toggles so stale bytes never look valid
    ib_rdata <= ib_rd ? mem[ib_addr] : ~ib_rdata;
    ib_op_done <= cnt == 1;
    if (cnt != 0) cnt <= cnt - 1;
    if (ib_erase) begin
      for (int i = 0; i < 16; i++) mem[i] <= 8'hff;
      cnt <= done_delay + 1;
    end else if (ib_prog) begin
      mem[{ib_prog_index, 1'b0}] <= ib_prog_data;
      mem[{ib_prog_index, 1'b1}] <= ~ib_prog_data;
      cnt <= done_delay + 1;
    end
  end
endmodule // info_block_model
`default_nettype wire

// ==== test/tb_top.sv ====
`include "option_loader_regs.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk, rst, wr_en, rd_en, irq, ib_rd, ib_prog, ib_erase, ib_op_done, err;
  logic options_valid, debug_disable, watchdog_select, no_reset_on_stop, rd_d = 1'b0;
  logic no_reset_on_standby, boot_select_bit, analog_supply_monitor_enable, ram_parity_enable;
  logic [7:0] addr, ib_rdata, ib_prog_data, b;
  logic [7:0] ld [0:7];
  logic [31:0] wdata, rdata, page_group_protect, e, r, seed = 32'he15e_1eba;
  logic [31:0] rq [$];
  logic [31:0] pq [$];
  logic [3:0] ib_addr, dly;
  logic [2:0] ib_prog_index;
  logic [1:0] read_protect_level, lv, m;
  int err_count = 0;
  int checks = 0;
  wire [5:0] uo = {ram_parity_enable, analog_supply_monitor_enable, boot_select_bit,
    no_reset_on_standby, no_reset_on_stop, watchdog_select};
  option_byte_loader uut (.core_clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq,
    .ib_addr, .ib_rd, .ib_rdata, .ib_prog, .ib_prog_index, .ib_prog_data, .ib_erase,
    .ib_op_done, .options_valid, .read_protect_level, .debug_disable, .watchdog_select,
    .no_reset_on_stop, .no_reset_on_standby, .boot_select_bit,
    .analog_supply_monitor_enable, .ram_parity_enable, .page_group_protect);
  info_block_model ib (.core_clk, .ib_addr, .ib_rd, .ib_rdata, .ib_prog, .ib_prog_index,
    .ib_prog_data, .ib_erase, .ib_op_done, .done_delay(dly));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %0t read data %h exp %h", $time, g, x);
    end
  endtask
  task automatic cmp_cmd(input logic [31:0] g, input logic [31:0] x);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("[ERR] %0t program command %h exp %h", $time, g, x);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    rd_en <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    addr <= a;
    wr_en <= 1'b0;
    rd_en <= 1'b1;
    @(posedge core_clk);
  endtask
  task automatic idle(input int n);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 40 && irq !== 1'b1; i++) idle(1);
  endtask
  task automatic unlock();
    wr(`OPTION_KEY_OFS, `KEY_FIRST);
    wr(`OPTION_KEY_OFS, `KEY_SECOND);
  endtask
  task automatic check_load();
    err = 1'b0;
    for (int k = 0; k < 8; k++) begin
      ld[k] = ib.mem[2*k];
      if (ld[k] !== ~ib.mem[2*k+1] && (ld[k] & ib.mem[2*k+1]) !== 8'hff) begin
        ld[k] = 8'hff;
        err = 1'b1;
      end
    end
    lv = ld[0] == 8'haa ? 2'h0 : ld[0] == 8'hcc ? 2'h2 : 2'h1;
    cmp(page_group_protect, ~{ld[7], ld[6], ld[5], ld[4]});
    cmp({debug_disable, read_protect_level}, {lv == 2'h2, lv});
    cmp(uo[3:0], {ld[1][4], ld[1][2:0]});
    cmp(uo[5:4], ld[1][6:5]);
    rd(`OBCS_OFS, {ld[3], ld[2], ld[1], 5'h0, lv, err});
    rd(`WRTPROT_OFS, {ld[7], ld[6], ld[5], ld[4]});
    wr(`IRQ_MASK_OFS, 32'h2);
    idle(1);
    cmp(irq, err);
    rd(`IRQ_STATUS_OFS, {30'h0, err, 1'b0});
    idle(2);
    cmp(irq, 1'b0);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    for (int i = 0; i < 40 && options_valid !== 1'b1; i++) idle(1);
    cmp(options_valid, 1'b1);
    check_load();
  endtask
  always @(posedge core_clk) begin
    rd_d <= rd_en;
    if (rd_d) begin
      e = rq.pop_front();
      cmp_rd(rdata, e);
    end
    if (ib_prog) begin
      e = pq.size() ? pq.pop_front() : 32'hffff_ffff;
      cmp_cmd({21'h0, ib_prog_index, ib_prog_data}, e);
    end
  end
  initial begin
    rst = 1'b1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    dly = 4'h0;
    for (int t = 0; t < 4; t++) begin
      for (int k = 0; k < 8; k++) begin
        r = rnd();
        b = k == 0 && t < 2 ? (t == 0 ? 8'haa : 8'hcc) : r[7:0];
        m = k == 0 && t < 2 ? 2'h0 : r[9:8];
        ib.mem[2*k] = m == 2'h1 ? 8'hff : b;
        ib.mem[2*k+1] = m == 2'h1 ? 8'hff : m == 2'h2 ? b ^ 8'h01 : ~b;
      end
      do_reset();
      if (t == 1) begin
        unlock();
        rd(`CTRL2_OFS, 32'h0);
      end
    end
    for (int k = 0; k < 16; k++) ib.mem[k] = k < 2 ? 8'haa ^ {8{k[0]}} : 8'hff;
    do_reset();
    rd(`CTRL2_OFS, 32'h0);
    rd(`OPTION_KEY_OFS, 32'h0);
    rd(8'h3c, 32'h0);
    r = rnd();
    wr(`FLASH_KEY_OFS, `KEY_FIRST);
    wr(`FLASH_KEY_OFS, `KEY_SECOND);
    wr(`CTRL2_OFS, 32'h1);
    idle(4);
    rd(`CTRL2_OFS, 32'h0);
    unlock();
    rd(`CTRL2_OFS, 32'h8);
    wr(`IRQ_MASK_OFS, 32'h1);
    wr(`OPT_DATA_OFS, {21'h0, 3'h2, r[7:0]});
    dly = 4'hc;
    pq.push_back({21'h0, 3'h2, r[7:0]});
    wr(`CTRL2_OFS, 32'h5);
    wait_irq();
    rd(`STATUS_OFS, 32'h20);
    rd(`IRQ_STATUS_OFS, 32'h1);
    wr(`CTRL2_OFS, 32'h0);
    rd(`CTRL2_OFS, 32'h8);
    rd(`OBCS_OFS, 32'hffff_ff00);
    do_reset();
    rd(`CTRL2_OFS, 32'h0);
    unlock();
    dly = 4'h0;
    wr(`IRQ_MASK_OFS, 32'h1);
    wr(`CTRL2_OFS, 32'h6);
    wait_irq();
    do_reset();
    idle(2);
    final_report();
  end
  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
